//--- common/ctr_gate_pkg.sv
//==========================================================
// Contract
// - Two independent 32-bit counters, each own index.
// - Channel list returns low half then high.
// - Internal source paces counter and pulse output.
// - External source starts on clock rising edge.
// - Base clock divided by divider, minimum two.
// - Counter sampled once per acquisition tick.
// - Gate none enables on software start.
// - Low-level gate counts while gate low.
// - High-level gate counts while gate high.
// - Falling gate edge enables counter operation.
// - Rising gate edge enables counter operation.
// - Count rising edges, wrap to zero.
package ctr_gate_pkg;
    //==========================================================
    // Sizes and encodings.
    localparam int CTR_WIDTH = 32;             // Counter width.
    localparam int HALF_WIDTH = 16;            // Channel list word width.
    localparam int NUM_CTR = 2;                // Counter count.
    localparam int BASE_CLK_HZ = 48000000;     // Base counting clock.
    localparam logic [31:0] DIV_MIN = 32'h00000002; // Smallest divider.
    localparam logic [31:0] DIV_RESET = 32'h00000002; // Divider after reset.
    localparam logic [31:0] CTR_RESET = 32'h00000000; // Count after reset.

    // Gate types selected by software.
    typedef enum logic [2:0] {
        GATE_NONE = 3'b000,
        GATE_LOW = 3'b001,
        GATE_HIGH = 3'b010,
        GATE_FALL = 3'b011,
        GATE_RISE = 3'b100
    } gate_t;

    // Channel list read sequencer states.
    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_LOW = 2'b01,
        RD_HIGH = 2'b10
    } rd_state_t;
endpackage

//--- dv/counter_clock_gate_frontend_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// Bench for the counter front end.
module counter_clock_gate_frontend_tb_top;
    import ctr_gate_pkg::*;
    //==========================================================
    // Stimulus and observed signals.
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] intClkSel = 2'h0;
    logic [5:0] gateTypeSel = 6'h00;
    logic [63:0] clkDivider = 64'h0000000200000002;
    logic [1:0] swStart = 2'h0;
    logic [1:0] swStop = 2'h0;
    logic [1:0] inList = 2'h0;
    logic sampleTick = 1'b0;
    wire logic [1:0] extClk, extGate;
    logic [1:0] pulseOut, ctrRunning;
    logic [15:0] listData;
    logic listValid, listHigh;
    logic [0:0] listIndex;
    int n_fail = 0;
    int cmp_count = 0;
    logic [31:0] v0, v1, exp0, exp1;
    int t0, t1;
    logic [1:0] pPrev; // Pulse levels one sample back.
    // Scenario table: gate types, levels before and after, expected gains.
    gate_t gA[3] = '{GATE_NONE, GATE_HIGH, GATE_RISE};
    gate_t gB[3] = '{GATE_LOW, GATE_FALL, GATE_NONE};
    logic [1:0] pre[3] = '{2'h3, 2'h2, 2'h0};
    logic [1:0] post[3] = '{2'h0, 2'h1, 2'h1};
    logic [31:0] addA[3] = '{32'h5, 32'h3, 32'h3};
    logic [31:0] addB[3] = '{32'h3, 32'h3, 32'h5};
    always #5 clk_sys = ~clk_sys;
    counter_clock_gate_frontend dut (.clk_sys(clk_sys), .rst_b(rst_b), .intClkSel(intClkSel),
        .gateTypeSel(gateTypeSel), .clkDivider(clkDivider), .swStart(swStart), .swStop(swStop),
        .inList(inList), .extClk(extClk), .extGate(extGate), .pulseOut(pulseOut), .ctrRunning(ctrRunning),
        .sampleTick(sampleTick), .listData(listData), .listValid(listValid), .listHigh(listHigh),
        .listIndex(listIndex));
    ext_pins_model ext (.clk_sys(clk_sys), .extClk(extClk), .extGate(extGate));
    //==========================================================
    // Shared tasks.
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // One tick, then four words collected under a bounded wait.
    task automatic readList(output logic [31:0] r0, output logic [31:0] r1);
        logic [15:0] w[4];
        int k;
        k = 0;
        @(posedge clk_sys);
        sampleTick <= 1'b1;
        @(posedge clk_sys);
        sampleTick <= 1'b0;
        for (int t = 0; t < 12 && k < 4; t++) begin
            @(posedge clk_sys);
            #1;
            if (listValid === 1'b1) begin
                check(32'(listHigh), 32'(k % 2), "word half");
                check(32'(listIndex), 32'(k / 2), "word counter");
                w[k] = listData;
                k++;
            end
        end
        if (k < 4) begin
            n_fail++;
            $display("mismatch at %0t: channel list words missing", $time);
            report_and_stop();
        end
        r0 = {w[1], w[0]};
        r1 = {w[3], w[2]};
    endtask
    task automatic pulseCmd(input logic start);
        @(posedge clk_sys);
        if (start) begin
            swStart <= 2'h3;
        end else begin
            swStop <= 2'h3;
        end
        @(posedge clk_sys);
        swStart <= 2'h0;
        swStop <= 2'h0;
    endtask
    //==========================================================
    // Main sequence.
    initial begin
        exp0 = 32'h0;
        exp1 = 32'h0;
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        inList <= 2'h3;
        for (int e = 0; e < 3; e++) begin
            ext.gate(pre[e]);
            gateTypeSel <= {gB[e], gA[e]};
            pulseCmd(1'b1);
            ext.pulses(2);
            ext.gate(post[e]);
            ext.pulses(3);
            repeat (4) @(posedge clk_sys);
            pulseCmd(1'b0);
            exp0 += addA[e];
            exp1 += addB[e];
            readList(v0, v1);
            check(v0, exp0, "count 0");
            check(v1, exp1, "count 1");
            $display("gate test %0d done", e);
        end
        // Internal source: divider 4 on counter 0, divider 1 clamped to 2 on counter 1.
        intClkSel <= 2'h3;
        clkDivider <= 64'h0000000100000004;
        gateTypeSel <= 6'h00;
        pulseCmd(1'b1);
        t0 = 0;
        t1 = 0;
        #1;
        pPrev = pulseOut;
        // Count pulse toggles over 40 cycles: two per divider period.
        repeat (40) begin
            @(posedge clk_sys);
            #1;
            t0 += int'(pulseOut[0] !== pPrev[0]);
            t1 += int'(pulseOut[1] !== pPrev[1]);
            pPrev = pulseOut;
        end
        check(32'(t0 >= 19 && t0 <= 21), 32'h1, "pulse toggles 0");
        check(32'(t1 >= 39 && t1 <= 41), 32'h1, "pulse toggles 1");
        check(32'(ctrRunning), 32'h3, "counters armed");
        pulseCmd(1'b0);
        readList(v0, v1);
        check(32'(v0 - exp0 >= 8 && v0 - exp0 <= 12), 32'h1, "internal rate 0");
        check(32'(v1 - exp1 >= 18 && v1 - exp1 <= 22), 32'h1, "internal rate 1");
        $display("internal clock test done");
        report_and_stop();
    end
endmodule
`default_nettype wire

//--- dv/ctr_frontend_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checker for the counter front end.
module ctr_frontend_monitor #(
    parameter int NUM = 2
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Inputs watched as causes.
    input wire logic [NUM-1:0] swStart,
    input wire logic [NUM-1:0] swStop,
    input wire logic [NUM-1:0] intClkSel,
    input wire logic [NUM-1:0] inList,
    input wire logic sampleTick,
    // Outputs under check.
    input wire logic [NUM-1:0] pulseOut,
    input wire logic [NUM-1:0] ctrRunning,
    input wire logic listValid,
    input wire logic listHigh,
    input wire logic [0:0] listIndex
);
    //==========================================================
    // Properties, all in the one clock domain.
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    low_then_high_a:
        assert property (listValid && !listHigh |=> listValid && listHigh && $stable(listIndex)) else $error("no high word");
    high_after_low_a:
        assert property (listValid && listHigh |-> $past(listValid) && !$past(listHigh)) else $error("lone high word");
    tick_to_word_a:
        assert property (listValid && !listHigh && !listIndex |-> $past(sampleTick, 2) && $past(inList[0], 2))
        else $error("word without tick");
    list_order_a:
        assert property (listValid && listHigh && !listIndex && inList[1] |=> listValid && !listHigh && listIndex)
        else $error("second counter missing");
    reset_quiet_a:
        assert property ($rose(rst_b) |-> !listValid && pulseOut == '0 && ctrRunning == '0) else $error("reset");
    start_arms_a:
        assert property (swStart[0] && !swStop[0] ##1 !swStop[0] |=> ctrRunning[0]) else $error("start lost");
    stop_disarms_a:
        assert property (swStop[1] ##1 !swStart[1] |=> !ctrRunning[1]) else $error("stop lost");
    ext_pulse_hold_a:
        assert property (!intClkSel[0] && !$past(intClkSel[0]) && !$past(intClkSel[0], 2) |-> $stable(pulseOut[0]))
        else $error("pulse moved");
endmodule
bind counter_clock_gate_frontend ctr_frontend_monitor #(.NUM(NUM)) mon (.clk_sys(clk_sys), .rst_b(rst_b),
    .swStart(swStart), .swStop(swStop), .intClkSel(intClkSel), .inList(inList), .sampleTick(sampleTick),
    .pulseOut(pulseOut), .ctrRunning(ctrRunning), .listValid(listValid), .listHigh(listHigh), .listIndex(listIndex));
`default_nettype wire

//--- dv/ext_pins_model.sv
`timescale 1ns/100ps
`default_nettype none
// External clock and gate wiring of both counters.
module ext_pins_model (
    // Clock.
    input wire logic clk_sys,
    // Pins.
    output logic [1:0] extClk,
    output logic [1:0] extGate
);
    initial extClk = 2'h0;
    initial extGate = 2'h0;
    // Pulses stay three cycles each way so the synchroniser sees them all.
    task automatic pulses(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (3) @(posedge clk_sys);
            extClk <= 2'h3;
            repeat (3) @(posedge clk_sys);
            extClk <= 2'h0;
        end
    endtask
    // New gate levels, then time for them to pass the synchroniser.
    task automatic gate(input logic [1:0] lvl);
        @(posedge clk_sys);
        extGate <= lvl;
        repeat (6) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

//--- hdl/counter_clock_gate_frontend.sv
`timescale 1ns/100ps
`default_nettype none
// Two counters plus the channel-list reader that splits a count into halves.
module counter_clock_gate_frontend #(
    parameter int NUM = 2,
    parameter int WIDTH = 32
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Per-counter configuration, packed by counter index.
    input wire logic [NUM-1:0] intClkSel,
    input wire logic [3*NUM-1:0] gateTypeSel,
    input wire logic [WIDTH*NUM-1:0] clkDivider,
    input wire logic [NUM-1:0] swStart,
    input wire logic [NUM-1:0] swStop,
    input wire logic [NUM-1:0] inList,
    // External wiring.
    input wire logic [NUM-1:0] extClk,
    input wire logic [NUM-1:0] extGate,
    output logic [NUM-1:0] pulseOut,
    output logic [NUM-1:0] ctrRunning,
    // Acquisition channel list.
    input wire logic sampleTick,
    output logic [ctr_gate_pkg::HALF_WIDTH-1:0] listData,
    output logic listValid,
    output logic listHigh,
    output logic [0:0] listIndex
);
    import ctr_gate_pkg::*;

    //==========================================================
    // Elaboration checks.
    // The reader below is written for exactly two channels whose counts
    // split into two list words each, so any other size is refused while
    // the design is built rather than giving a quietly wrong channel list.
    if (NUM != NUM_CTR || WIDTH != CTR_WIDTH) begin : gBadSize
        $error("Only two 32-bit counters are supported.");
    end

    //==========================================================
    // Counter channels, each with its own subsystem index.
    // Each channel is complete in itself: its own synchronisers, gate logic,
    // divider and counter. The two never share state, so starting, stopping
    // or reconfiguring one leaves the other untouched.
    // Limitation: the counts are never cleared except by reset, so a host
    // that wants a fresh measurement works with the difference of two
    // readings; the natural wrap keeps that difference right.
    logic [WIDTH-1:0] cnt [NUM]; // Live count of each channel.
    logic [NUM-1:0] pulseW, runW; // Pulse and armed bits straight from the channels.
    logic [NUM-1:0] pulse_r, run_r; // Output flops for the pulse and armed bits.
    genvar g; // Loop index of the channel generate block.
    generate
        // One pass per counter; the packed configuration buses are sliced
        // by the counter index.
        for (g = 0; g < NUM; g++) begin : gCh
            logic [WIDTH-1:0] divSafe; // Divider after the lower clamp.
            // Dividers below two are clamped to two.
            // A divider of one would give a period of a single cycle, too
            // short for the two toggles that each pulse period needs.
            assign divSafe = (clkDivider[g*WIDTH +: WIDTH] < WIDTH'(DIV_MIN)) ?
                WIDTH'(DIV_MIN) : clkDivider[g*WIDTH +: WIDTH];
            // Unused gate type codes fall into the channel's default branch
            // and never enable counting, so a stray value is harmless.
            ctr_channel #(.WIDTH(WIDTH)) uCh (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .intClkSel(intClkSel[g]),
                .gateType(gate_t'(gateTypeSel[g*3 +: 3])),
                .clkDivider(divSafe),
                .swStart(swStart[g]),
                .swStop(swStop[g]),
                .extClk(extClk[g]),
                .extGate(extGate[g]),
                .count(cnt[g]),
                .pulseOut(pulseW[g]),
                .running(runW[g])
            );
        end
    endgenerate

    //==========================================================
    // Channel list reader state.
    rd_state_t st_r, st_nxt; // Where the reader stands in its word sequence.
    logic [WIDTH-1:0] snap_r, snap_nxt; // Captured counter value.
    logic [0:0] idx_r, idx_nxt; // Counter being emitted.
    logic [NUM-1:0] pend_r, pend_nxt; // Counters still owed this tick.
    logic [HALF_WIDTH-1:0] data_r, data_nxt; // List word on its way out.
    logic valid_r, valid_nxt; // A list word stands this cycle.
    logic high_r, high_nxt; // The standing word is the upper half.
    logic [0:0] lidx_r, lidx_nxt; // Counter that the standing word belongs to.

    //==========================================================
    // Channel list reader.
    // A tick snapshots listed counters in turn; each gives low then high.
    // A tick arriving mid-list is dropped, so the tick rate must leave
    // two cycles per listed counter plus one idle cycle.
    // A refused tick gives no sign of its own; the host sees it only as a
    // missing list, which is why the tick spacing is left to the pacing.
    // Both halves come from one snapshot, so a carry out of the lower half
    // between the two words can never tear the value that the host sees.
    // The price is one cycle of latency before the first word.

    // Timing of one list, counted from the edge that takes the tick: one
    // edge later the reader is in its low state, two edges later the low
    // word stands for one cycle and three edges later the high word. With
    // both counters listed, counter one follows at four and five edges.
    // Counter one is captured when its own low state begins, so its value
    // is two cycles younger than that of counter zero.
    always_comb begin
        // Hold the state by default; the word strobes are single pulses.
        st_nxt = st_r;
        snap_nxt = snap_r;
        idx_nxt = idx_r;
        pend_nxt = pend_r;
        data_nxt = data_r;
        valid_nxt = 1'b0;
        high_nxt = 1'b0;
        lidx_nxt = lidx_r;
        case (st_r)
            RD_IDLE: begin
                // Only a tick with at least one listed counter starts a list.
                if (sampleTick && inList != '0) begin
                    pend_nxt = inList;
                    // The lowest listed counter goes first.
                    idx_nxt = inList[0] ? 1'b0 : 1'b1;
                    snap_nxt = inList[0] ? cnt[0] : cnt[1];
                    st_nxt = RD_LOW;
                end
            end

            RD_LOW: begin
                // First entry: the lower half of the snapshot.
                data_nxt = snap_r[HALF_WIDTH-1:0];
                valid_nxt = 1'b1;
                // The counter index travels with the word for the host.
                lidx_nxt = idx_r;
                st_nxt = RD_HIGH;
            end

            RD_HIGH: begin
                // Second entry: the upper half of the same snapshot.
                data_nxt = snap_r[WIDTH-1:HALF_WIDTH];
                valid_nxt = 1'b1;
                high_nxt = 1'b1;
                lidx_nxt = idx_r;
                // The counter just finished is no longer owed.
                pend_nxt = pend_r & ~(2'b01 << idx_r);
                if (idx_r == 1'b0 && pend_r[1]) begin
                    // Counter one is still owed: capture it and go on.
                    idx_nxt = 1'b1;
                    snap_nxt = cnt[1];
                    st_nxt = RD_LOW;
                end else begin
                    // Nothing is left for this tick; wait for the next.
                    st_nxt = RD_IDLE;
                end
            end

            default: begin
                // An unused state code returns to idle.
                st_nxt = RD_IDLE;
            end
        endcase
    end

    //==========================================================
    // Register stage for the reader and the output flops.
    // Reset is synchronous; every flop returns to a quiet idle value so
    // that no list word and no pulse edge leaks out just after release.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            // Reset: idle reader, nothing owed, every output low.
            st_r <= RD_IDLE;
            snap_r <= WIDTH'(CTR_RESET);
            idx_r <= 1'b0;
            pend_r <= '0;
            data_r <= '0;
            valid_r <= 1'b0;
            high_r <= 1'b0;
            lidx_r <= 1'b0;
            pulse_r <= '0;
            run_r <= '0;
        end else begin
            // Normal operation: every register takes its next value.
            st_r <= st_nxt;
            snap_r <= snap_nxt;
            idx_r <= idx_nxt;
            pend_r <= pend_nxt;
            data_r <= data_nxt;
            valid_r <= valid_nxt;
            high_r <= high_nxt;
            lidx_r <= lidx_nxt;
            // The pulse and armed bits pass one more flop, so that every
            // output of the block comes straight from a register here.
            pulse_r <= pulseW;
            run_r <= runW;
        end
    end

    //==========================================================
    // Outputs.
    // Pulse output and armed state lag the channel by one cycle; the
    // list outputs are the reader's own flops.
    assign pulseOut = pulse_r;
    assign ctrRunning = run_r;
    assign listData = data_r;
    assign listValid = valid_r;
    assign listHigh = high_r;
    assign listIndex = lidx_r;
endmodule
`default_nettype wire

//--- hdl/ctr_channel.sv
`timescale 1ns/100ps
`default_nettype none
// One counter channel: synchroniser, gate logic, divider, counter.
module ctr_channel #(
    parameter int WIDTH = 32
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Configuration.
    input wire logic intClkSel,
    input wire ctr_gate_pkg::gate_t gateType,
    input wire logic [WIDTH-1:0] clkDivider,
    input wire logic swStart,
    input wire logic swStop,
    // External signals.
    input wire logic extClk,
    input wire logic extGate,
    // Results.
    output logic [WIDTH-1:0] count,
    output logic pulseOut,
    output logic running
);
    import ctr_gate_pkg::*;

    // A counter narrower than two bits cannot hold the smallest divider.
    if (WIDTH < 2) begin : gBadWidth
        $error("Counter width must be at least two bits.");
    end

    //==========================================================
    // State.
    logic clkMeta_r, clkSync_r, clkPrev_r;   // External clock sync chain.
    logic gateMeta_r, gateSync_r, gatePrev_r; // Gate sync chain.
    logic armed_r, armed_nxt;                // Software start seen.
    logic enabled_r, enabled_nxt;            // Edge-gate latch.
    logic [WIDTH-1:0] divCnt_r, divCnt_nxt;  // Divider phase.
    logic [WIDTH-1:0] count_r, count_nxt;    // The counter itself.
    logic pulse_r, pulse_nxt;                // Pulse output toggle.
    logic tick;                              // One counting event.
    logic gateOk;                            // Gate lets counting run.
    logic [WIDTH-1:0] halfDiv;               // Half period for the pulse.

    // Edge and level logic reads only second and third stages.
    always_comb begin
        halfDiv = clkDivider >> 1;
        armed_nxt = (armed_r | swStart) & ~swStop;
        enabled_nxt = enabled_r;
        gateOk = 1'b0;
        case (gateType)
            GATE_NONE: gateOk = armed_r;
            GATE_LOW: gateOk = armed_r & ~gateSync_r;
            GATE_HIGH: gateOk = armed_r & gateSync_r;
            GATE_FALL: begin
                if (armed_r && gatePrev_r && !gateSync_r) begin
                    enabled_nxt = 1'b1;
                end
                gateOk = enabled_r;
            end
            GATE_RISE: begin
                if (armed_r && !gatePrev_r && gateSync_r) begin
                    enabled_nxt = 1'b1;
                end
                gateOk = enabled_r;
            end
            default: gateOk = 1'b0;
        endcase
        if (!armed_nxt) begin
            enabled_nxt = 1'b0;
        end
        // Divider runs always so the pulse output keeps its rate.
        divCnt_nxt = divCnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
        pulse_nxt = pulse_r;
        if (divCnt_r >= clkDivider - {{(WIDTH-1){1'b0}}, 1'b1}) begin
            divCnt_nxt = '0;
        end
        if (intClkSel) begin
            // Pulse toggles at half and full period.
            if (divCnt_r == '0 || divCnt_r == halfDiv) begin
                pulse_nxt = ~pulse_r;
            end
            tick = (divCnt_r == '0);
        end else begin
            // Only a synchronised rising edge counts.
            tick = clkSync_r & ~clkPrev_r;
        end
        // Natural wrap to zero after the full range.
        count_nxt = (tick && gateOk) ? count_r + {{(WIDTH-1){1'b0}}, 1'b1} : count_r;
    end

    // Register stage; synchronisers included.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            clkMeta_r <= 1'b0;
            clkSync_r <= 1'b0;
            clkPrev_r <= 1'b0;
            gateMeta_r <= 1'b0;
            gateSync_r <= 1'b0;
            gatePrev_r <= 1'b0;
            armed_r <= 1'b0;
            enabled_r <= 1'b0;
            divCnt_r <= '0;
            count_r <= '0;
            pulse_r <= 1'b0;
        end else begin
            clkMeta_r <= extClk;
            clkSync_r <= clkMeta_r;
            clkPrev_r <= clkSync_r;
            gateMeta_r <= extGate;
            gateSync_r <= gateMeta_r;
            gatePrev_r <= gateSync_r;
            armed_r <= armed_nxt;
            enabled_r <= enabled_nxt;
            divCnt_r <= divCnt_nxt;
            count_r <= count_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign count = count_r;
    assign pulseOut = pulse_r;
    assign running = armed_r;
endmodule
`default_nettype wire
